// ---- design/spi_pin_pkg.sv ----
package spi_pin_pkg;
  // select_line_mode encodings
  localparam logic [1:0] SEL_3WIRE = 2'h0;
  localparam logic [1:0] SEL_4WIRE_IN = 2'h1;
  localparam int SEL_UPPER = 1;
  localparam int SEL_LOWER = 0;
  localparam logic [1:0] SEL_RESET = 2'h1;
  // register offsets
  localparam logic [1:0] ADDR_CTRL = 2'h0;
  localparam logic [1:0] ADDR_DATA = 2'h1;
  localparam logic [1:0] ADDR_CLKDIV = 2'h2;
  // control register field positions
  localparam int CTL_EN = 0;
  localparam int CTL_SELM_LO = 2;
  localparam int CTL_SELM_HI = 3;
  localparam int CTL_MODE_FAULT_FLAG = 5;
  localparam int CTL_MST = 6;
  localparam int CTL_DONE = 7;
  localparam logic [7:0] CLKDIV_RESET = 8'h04;
  // least select setup before first active clock, in system clocks
  localparam int SEL_SETUP_CLKS = 2;
  localparam int BYTE_BITS = 8;
endpackage

// ---- design/spi_sync_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface spi_sync_if;
  logic sck_raw;
  logic sel_raw;
  logic sck_s;
  logic sel_s;
  logic mosi_raw;
  logic miso_raw;
  logic mosi_s;
  logic miso_s;
  modport sync (input sck_raw, input sel_raw, input mosi_raw,
    input miso_raw, output sck_s, output sel_s, output mosi_s,
    output miso_s);
  modport core (output sck_raw, output sel_raw, output mosi_raw,
    output miso_raw, input sck_s, input sel_s, input mosi_s,
    input miso_s);
endinterface
`default_nettype wire

// ---- design/spi_pin_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module spi_pin_sync (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pins in, synchronised levels out
  spi_sync_if.sync sif
);
  logic [1:0] sck_q;
  logic [1:0] sel_q;
  logic [1:0] mosi_q;
  logic [1:0] miso_q;

  // two-flop synchronisers, stage 0 read only by stage 1
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_q <= 2'h0;
      sel_q <= 2'h3;
      mosi_q <= 2'h0;
      miso_q <= 2'h0;
    end else begin
      sck_q <= {sck_q[0], sif.sck_raw};
      sel_q <= {sel_q[0], sif.sel_raw};
      mosi_q <= {mosi_q[0], sif.mosi_raw};
      miso_q <= {miso_q[0], sif.miso_raw};
    end
  end

  assign sif.sck_s = sck_q[1];
  assign sif.sel_s = sel_q[1];
  assign sif.mosi_s = mosi_q[1];
  assign sif.miso_s = miso_q[1];
endmodule
`default_nettype wire

// ---- design/spi_pin_select.sv ----
// The placing of the registers and the plain strobed port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module spi_pin_select
  import spi_pin_pkg::*;
#(
  parameter int DATA_BITS = BYTE_BITS
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // serial clock pin
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe,
  // master-out slave-in pin
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe,
  // master-in slave-out pin
  input wire logic miso_in,
  output logic miso_out,
  output logic miso_oe,
  // select pin
  input wire logic sel_n_in,
  output logic sel_n_out,
  output logic sel_n_oe,
  output logic sel_pinned
);
  if (DATA_BITS != BYTE_BITS) begin : g_width_check
    $error("DATA_BITS must be 8");
  end

  typedef enum logic [1:0] {ST_IDLE, ST_LOW, ST_HIGH} mst_state_t;

  //////////////////////////////////////////////////////////////////////////
  spi_sync_if sif ();
  assign sif.sck_raw = sck_in;
  assign sif.sel_raw = sel_n_in;
  assign sif.mosi_raw = mosi_in;
  assign sif.miso_raw = miso_in;

  spi_pin_sync u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .sif(sif)
  );

  //////////////////////////////////////////////////////////////////////////
  logic en_q;
  logic mst_q;
  logic mode_fault_flag_q;
  logic done_q;
  logic [1:0] selm_q;
  logic [7:0] clkdiv_q;
  logic [7:0] shift_q;
  logic [7:0] rx_q;
  logic [2:0] bit_q;
  logic [7:0] div_q;
  logic sck_d1_q;
  logic sel_d1_q;
  logic sampled_q;
  logic rx_bit_q;
  mst_state_t mst_state_q;

  logic wr_ctrl;
  logic wr_data;
  logic sel_fall;
  logic mfault;
  logic slave_on;
  logic slave_sel;
  logic sck_rise;
  logic sck_fall;
  logic byte_end_s;
  logic byte_end_m;
  logic m_sample;
  logic m_shift;

  assign wr_ctrl = reg_wr && (reg_addr == ADDR_CTRL);
  assign wr_data = reg_wr && (reg_addr == ADDR_DATA);
  assign sel_fall = sel_d1_q && !sif.sel_s;
  // mode-01 master sees select fall
  assign mfault = en_q && mst_q && (selm_q == SEL_4WIRE_IN) && sel_fall;
  assign slave_on = en_q && !mst_q;
  // 3-wire slave always selected, 4-wire by low select
  assign slave_sel = slave_on && ((selm_q == SEL_3WIRE) ||
    ((selm_q == SEL_4WIRE_IN) && !sif.sel_s));
  assign sck_rise = slave_sel && sif.sck_s && !sck_d1_q;
  assign sck_fall = slave_sel && !sif.sck_s && sck_d1_q;
  assign byte_end_s = sck_fall && sampled_q && (bit_q == 3'h7);
  assign m_sample = (mst_state_q == ST_LOW) && (div_q == 8'h00);
  assign m_shift = (mst_state_q == ST_HIGH) && (div_q == 8'h00);
  assign byte_end_m = m_shift && (bit_q == 3'h7);

  //////////////////////////////////////////////////////////////////////////
  // control register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      en_q <= 1'b0;
      mst_q <= 1'b0;
      selm_q <= SEL_RESET;
      clkdiv_q <= CLKDIV_RESET;
    end else if (mfault) begin
      en_q <= 1'b0;
      mst_q <= 1'b0;
    end else if (wr_ctrl) begin
      en_q <= reg_wdata[CTL_EN];
      mst_q <= reg_wdata[CTL_MST];
      selm_q <= reg_wdata[CTL_SELM_HI:CTL_SELM_LO];
    end else if (reg_wr && (reg_addr == ADDR_CLKDIV)) begin
      clkdiv_q <= reg_wdata;
    end
  end

  // sticky flags: set wins over software clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_fault_flag_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      if (mfault) begin
        mode_fault_flag_q <= 1'b1;
      end else if (wr_ctrl && !reg_wdata[CTL_MODE_FAULT_FLAG]) begin
        mode_fault_flag_q <= 1'b0;
      end
      if (byte_end_s || byte_end_m) begin
        done_q <= 1'b1;
      end else if (wr_ctrl && !reg_wdata[CTL_DONE]) begin
        done_q <= 1'b0;
      end
    end
  end

  // edge history
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_d1_q <= 1'b0;
      sel_d1_q <= 1'b1;
    end else begin
      sck_d1_q <= sif.sck_s;
      sel_d1_q <= sif.sel_s;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // master clock generator
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mst_state_q <= ST_IDLE;
      div_q <= 8'h00;
    end else if (!(en_q && mst_q)) begin
      mst_state_q <= ST_IDLE;
      div_q <= 8'h00;
    end else begin
      case (mst_state_q)
        ST_IDLE: begin
          if (wr_data) begin
            mst_state_q <= ST_LOW;
            div_q <= clkdiv_q;
          end
        end
        ST_LOW: begin
          if (div_q == 8'h00) begin
            mst_state_q <= ST_HIGH;
            div_q <= clkdiv_q;
          end else begin
            div_q <= div_q - 8'h01;
          end
        end
        ST_HIGH: begin
          if (div_q != 8'h00) begin
            div_q <= div_q - 8'h01;
          end else if (bit_q == 3'h7) begin
            mst_state_q <= ST_IDLE;
          end else begin
            mst_state_q <= ST_LOW;
            div_q <= clkdiv_q;
          end
        end
        default: mst_state_q <= ST_IDLE;
      endcase
    end
  end

  // shift register, bit counter, receive byte
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_q <= 8'h00;
      rx_q <= 8'h00;
      bit_q <= 3'h0;
      sampled_q <= 1'b0;
      rx_bit_q <= 1'b0;
    end else if (!en_q) begin
      bit_q <= 3'h0;
      sampled_q <= 1'b0;
    end else if (mst_q) begin
      if (wr_data && (mst_state_q == ST_IDLE)) begin
        shift_q <= reg_wdata;
        bit_q <= 3'h0;
      end else if (m_sample) begin
        rx_bit_q <= sif.miso_s;
      end else if (m_shift) begin
        shift_q <= {shift_q[6:0], rx_bit_q};
        bit_q <= bit_q + 3'h1;
        if (bit_q == 3'h7) begin
          rx_q <= {shift_q[6:0], rx_bit_q};
        end
      end
    end else begin
      if (slave_on && (selm_q == SEL_4WIRE_IN) && sel_fall) begin
        bit_q <= 3'h0;
        sampled_q <= 1'b0;
      end else if (wr_data && (bit_q == 3'h0) && !sampled_q) begin
        shift_q <= reg_wdata;
      end else if (sck_rise) begin
        rx_bit_q <= sif.mosi_s;
        sampled_q <= 1'b1;
      end else if (sck_fall && sampled_q) begin
        shift_q <= {shift_q[6:0], rx_bit_q};
        bit_q <= bit_q + 3'h1;
        sampled_q <= 1'b0;
        if (bit_q == 3'h7) begin
          rx_q <= {shift_q[6:0], rx_bit_q};
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // pin drivers, all registered
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_out <= 1'b0;
      sck_oe <= 1'b0;
      mosi_out <= 1'b0;
      mosi_oe <= 1'b0;
      miso_out <= 1'b0;
      miso_oe <= 1'b0;
      sel_n_out <= 1'b1;
      sel_n_oe <= 1'b0;
      sel_pinned <= 1'b1;
    end else begin
      sck_oe <= en_q && mst_q;
      sck_out <= (mst_state_q == ST_HIGH) ||
        ((mst_state_q == ST_LOW) && (div_q == 8'h00));
      mosi_oe <= en_q && mst_q;
      mosi_out <= shift_q[7];
      miso_out <= shift_q[7];
      miso_oe <= slave_on && ((selm_q == SEL_3WIRE) ||
        (!selm_q[SEL_UPPER] && !sif.sel_s));
      sel_n_oe <= selm_q[SEL_UPPER];
      sel_n_out <= selm_q[SEL_LOWER];
      sel_pinned <= (selm_q != SEL_3WIRE);
    end
  end

  // register read, data one cycle after strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if (reg_addr == ADDR_CTRL) begin
        reg_rdata <= {done_q, mst_q, mode_fault_flag_q, 1'b0, selm_q, 1'b0, en_q};
      end else if (reg_addr == ADDR_DATA) begin
        reg_rdata <= rx_q;
      end else if (reg_addr == ADDR_CLKDIV) begin
        reg_rdata <= clkdiv_q;
      end else begin
        reg_rdata <= 8'h00;
      end
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  a_fault_clears: assert property (@(posedge clk) disable iff (!rst_n)
    mfault |=> !en_q && !mst_q && mode_fault_flag_q)
    else $error("mode fault did not clear enables");
  a_miso_release: assert property (@(posedge clk) disable iff (!rst_n)
    !en_q ##1 !en_q |=> !miso_oe)
    else $error("miso driven while disabled");
  a_mosi_drive: assert property (@(posedge clk) disable iff (!rst_n)
    (en_q && mst_q) ##1 (en_q && mst_q) |-> mosi_oe && !miso_oe)
    else $error("master pin directions wrong");
  a_sel_output: assert property (@(posedge clk) disable iff (!rst_n)
    selm_q[SEL_UPPER] |=> sel_n_oe && (sel_n_out == $past(selm_q[0])))
    else $error("select output wrong");
  a_ignore_sck: assert property (@(posedge clk) disable iff (!rst_n)
    (slave_on && selm_q == SEL_4WIRE_IN && sif.sel_s && !sel_fall)
      |=> $stable(bit_q))
    else $error("deselected slave counted clock");
  a_count_reset: assert property (@(posedge clk) disable iff (!rst_n)
    (slave_on && selm_q == SEL_4WIRE_IN && sel_fall) |=> bit_q == 3'h0)
    else $error("bit counter not reset");
  a_three_drive: assert property (@(posedge clk) disable iff (!rst_n)
    (slave_on && selm_q == SEL_3WIRE) |=> miso_oe)
    else $error("3-wire slave released miso");
  a_done_set: assert property (@(posedge clk) disable iff (!rst_n)
    (byte_end_s || byte_end_m) |=> done_q)
    else $error("done flag not set after byte");
  a_mosi_msb: assert property (@(posedge clk) disable iff (!rst_n)
    1'b1 |=> mosi_out == $past(shift_q[7]))
    else $error("mosi not from top bit");
  c_fault: cover property (@(posedge clk) mfault);
  c_slave_byte: cover property (@(posedge clk) byte_end_s);
  c_master_byte: cover property (@(posedge clk) byte_end_m);
endmodule
`default_nettype wire

// ---- sim/spi_far_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module spi_far_model (
  // bus as seen at the far end
  input wire logic sck_pin,
  input wire logic mosi_pin,
  input wire logic miso_pin,
  // lines driven by the far end
  output logic far_sck,
  output logic far_mosi,
  output logic far_miso,
  output logic far_sel_n
);
  logic mst_on = 1'b0;
  logic slv_on = 1'b0;
  logic [7:0] slv_tx;
  logic [7:0] slv_rx;
  initial begin
    far_sck = 1'b0;
    far_mosi = 1'b0;
    far_miso = 1'b0;
    far_sel_n = 1'b1;
  end
  // released lines never keep their last value
  always #20 if (!mst_on) far_mosi = ~far_mosi;
  always #20 if (!slv_on) far_miso = ~far_miso;
  ////////////////////////////////////////////////////////////////////////////
  task automatic slave_load(input logic [7:0] tx);
    slv_tx = tx;
    slv_on = 1'b1;
    far_miso = tx[7];
  endtask
  always @(posedge sck_pin) begin
    if (slv_on) slv_rx = {slv_rx[6:0], mosi_pin};
  end
  always @(negedge sck_pin) begin
    if (slv_on) begin
      slv_tx = {slv_tx[6:0], 1'b0};
      far_miso = slv_tx[7];
    end
  end
  task automatic select(input logic v);
    far_sel_n = v;
  endtask
  task automatic stray_pulses(input int n);
    repeat (n) begin
      #80 far_sck = 1'b1;
      #80 far_sck = 1'b0;
    end
  endtask
  // far master paces the clock, select leads first edge by eight clocks
  task automatic master_xfer(input logic [7:0] tx, output logic [7:0] rx);
    mst_on = 1'b1;
    far_sel_n = 1'b0;
    #80;
    for (int i = 7; i >= 0; i--) begin
      far_mosi = tx[i];
      #80 far_sck = 1'b1;
      #80 rx[i] = miso_pin;
      far_sck = 1'b0;
    end
    #80 far_sel_n = 1'b1;
    mst_on = 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- sim/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin \
  fail_count++; $display("unexpected at %0t: got %h expected %h", \
  $time, got, exp); end end
module testbench;
  import spi_pin_pkg::*;
  logic clk, rst_n, reg_wr, reg_rd;
  logic [1:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rd, got;
  logic sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe;
  logic sel_n_out, sel_n_oe, sel_pinned;
  logic far_sck, far_mosi, far_miso, far_sel_n;
  int fail_count = 0;
  int checks_done = 0;
  int cycles = 0;
  wire logic sck_pin = sck_oe ? sck_out : far_sck;
  wire logic mosi_pin = mosi_oe ? mosi_out : far_mosi;
  wire logic miso_pin = miso_oe ? miso_out : far_miso;
  wire logic sel_pin = sel_n_oe ? sel_n_out : far_sel_n;
  spi_pin_select dut_u (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .sck_in(sck_pin), .sck_out(sck_out),
    .sck_oe(sck_oe), .mosi_in(mosi_pin), .mosi_out(mosi_out),
    .mosi_oe(mosi_oe), .miso_in(miso_pin), .miso_out(miso_out),
    .miso_oe(miso_oe), .sel_n_in(sel_pin), .sel_n_out(sel_n_out),
    .sel_n_oe(sel_n_oe), .sel_pinned(sel_pinned));
  spi_far_model far_u (.sck_pin(sck_pin), .mosi_pin(mosi_pin),
    .miso_pin(miso_pin), .far_sck(far_sck), .far_mosi(far_mosi),
    .far_miso(far_miso), .far_sel_n(far_sel_n));
  ////////////////////////////////////////////////////////////////////////////
  task automatic reg_write(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_read(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic check_reg(input logic [1:0] a, input logic [7:0] exp);
    reg_read(a, rd);
    `CHK(rd, exp)
  endtask
  task automatic settle;
    repeat (5) @(posedge clk);
    #1;
  endtask
  task automatic wait_done;
    int n;
    n = 0;
    rd = 8'h00;
    while (rd[CTL_DONE] !== 1'b1 && n < 100) begin
      reg_read(ADDR_CTRL, rd);
      n++;
    end
  endtask
  task automatic end_of_test;
    if (fail_count == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      end_of_test();
    end
  end
  initial begin
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 2'h0;
    reg_wdata = 8'h00;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    `CHK(sck_oe | mosi_oe | miso_oe | sel_n_oe, 1'b0)
    `CHK(sel_pinned, 1'b1)
    check_reg(ADDR_CTRL, 8'h04);
    check_reg(ADDR_CLKDIV, CLKDIV_RESET);
    check_reg(2'h3, 8'h00);
    // master with select driven low
    reg_write(ADDR_CTRL, 8'h49);
    settle();
    `CHK({sel_n_oe, sel_n_out}, 2'b10)
    `CHK({sck_oe, mosi_oe, miso_oe}, 3'b110)
    far_u.slave_load(8'h3C);
    reg_write(ADDR_DATA, 8'hA5);
    wait_done();
    `CHK(rd, 8'hC9)
    `CHK(far_u.slv_rx, 8'hA5)
    check_reg(ADDR_DATA, 8'h3C);
    far_u.slv_on = 1'b0;
    reg_write(ADDR_CTRL, 8'h4D);
    settle();
    `CHK({sel_n_oe, sel_n_out}, 2'b11)
    // 3-wire slave
    reg_write(ADDR_CTRL, 8'h01);
    reg_write(ADDR_DATA, 8'h96);
    settle();
    `CHK({sel_pinned, miso_oe, sck_oe, mosi_oe}, 4'b0100)
    far_u.master_xfer(8'h5A, got);
    `CHK(got, 8'h96)
    wait_done();
    `CHK(rd, 8'h81)
    check_reg(ADDR_DATA, 8'h5A);
    // 4-wire slave, clock ignored while deselected
    reg_write(ADDR_CTRL, 8'h05);
    reg_write(ADDR_DATA, 8'hC3);
    settle();
    `CHK({sel_pinned, miso_oe}, 2'b10)
    far_u.stray_pulses(3);
    far_u.master_xfer(8'h2B, got);
    `CHK(got, 8'hC3)
    wait_done();
    `CHK(rd, 8'h85)
    check_reg(ADDR_DATA, 8'h2B);
    // select fall while enabled master
    reg_write(ADDR_CTRL, 8'h45);
    settle();
    `CHK(mosi_oe, 1'b1)
    far_u.select(1'b0);
    settle();
    `CHK({sck_oe, mosi_oe}, 2'b00)
    check_reg(ADDR_CTRL, 8'h24);
    far_u.select(1'b1);
    reg_write(ADDR_CTRL, 8'h04);
    settle();
    `CHK({sck_oe, mosi_oe, miso_oe}, 3'b000)
    end_of_test();
  end
endmodule
`default_nettype wire
